// ==== design/rtcw_pkg.sv ====
// shared constants for the clock/calendar register window access block
package rtcw_pkg;
    // data widths
    localparam int RTCW_DW = 16;
    localparam int RTCW_BW = 8;
    localparam int RTCW_PW = 2;
    // byte slots per window: index = pointer * 2 + high-byte flag
    localparam int RTCW_SLOTS = 8;
    // field positions in the two configuration registers
    localparam int RTCW_PTR_LSB = 8;
    localparam int RTCW_PTR_MSB = 9;
    localparam int RTCW_WREN_BIT = 13;
    // window select codes
    localparam logic RTCW_WIN_VALUE = 1'h0;
    localparam logic RTCW_WIN_ALARM = 1'h1;
    // pointer codes
    localparam logic [1:0] RTCW_PTR_MIN_SEC = 2'h0;
    localparam logic [1:0] RTCW_PTR_WD_HR = 2'h1;
    localparam logic [1:0] RTCW_PTR_MON_DAY = 2'h2;
    localparam logic [1:0] RTCW_PTR_YEAR = 2'h3;
    localparam logic [1:0] RTCW_PTR_STEP = 2'h1;
    // reset values
    localparam logic [7:0] RTCW_BYTE_RST = 8'h00;
    localparam logic [15:0] RTCW_WORD_RST = 16'h0000;
    // unlock window: one instruction cycle, one clock at 250 MHz
    localparam int RTCW_CLK_PS = 4000;
    localparam int RTCW_UNLOCK_WIN_PS = 4000;
    localparam int RTCW_UNLOCK_CYC_I = (RTCW_UNLOCK_WIN_PS / RTCW_CLK_PS) < 1 ? 1 : (RTCW_UNLOCK_WIN_PS / RTCW_CLK_PS);
    localparam logic [3:0] RTCW_UNLOCK_CYC = 4'(RTCW_UNLOCK_CYC_I);
    localparam logic [3:0] RTCW_CNT_ZERO = 4'h0;
    localparam logic [3:0] RTCW_CNT_ONE = 4'h1;
    // unlock state machine, one-hot
    typedef enum logic [1:0] {
        RTCW_LOCKED = 2'b01,
        RTCW_ARMED = 2'b10
    } rtcw_unlock_e;
endpackage

// ==== design/rtcw_ptr.sv ====
// two-bit window pointer: direct load or step down, holding at zero
`timescale 1ns/1ps
`default_nettype none
module rtcw_ptr (
    // clock, reset, enable
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    // control
    input wire logic load,
    input wire logic [rtcw_pkg::RTCW_PW-1:0] load_val,
    input wire logic dec,
    // state
    output logic [rtcw_pkg::RTCW_PW-1:0] ptr
);
    import rtcw_pkg::*;

    logic [RTCW_PW-1:0] next_ptr; // next pointer value

    // load has priority; stepping stops at zero
    always_comb begin
        next_ptr = ptr;
        if (load) begin
            next_ptr = load_val;
        end else if (dec && ptr != RTCW_PTR_MIN_SEC) begin
            next_ptr = ptr - RTCW_PTR_STEP;
        end
    end

    // register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ptr <= RTCW_PTR_MIN_SEC;
        end else if (ce) begin
            ptr <= next_ptr;
        end
    end
endmodule
`default_nettype wire

// ==== design/rtcw_access.sv ====
// clock/calendar register window access: pointers, windows and write lock
`timescale 1ns/1ps
`default_nettype none
module rtcw_access (
    // clock, reset, enable
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    // configuration writes
    input wire logic cfg_wr,
    input wire logic [rtcw_pkg::RTCW_DW-1:0] cfg_wdata,
    input wire logic alcfg_wr,
    input wire logic [rtcw_pkg::RTCW_DW-1:0] alcfg_wdata,
    // unlock sequence completion
    input wire logic unlock_done,
    // window access
    input wire logic win_rd,
    input wire logic win_wr,
    input wire logic win_sel,
    input wire logic be_hi,
    input wire logic be_lo,
    input wire logic [rtcw_pkg::RTCW_DW-1:0] win_wdata,
    // read answer
    output logic [rtcw_pkg::RTCW_DW-1:0] rd_data,
    output logic rd_valid,
    // state views
    output logic [rtcw_pkg::RTCW_DW-1:0] rtc_config_calibration_reg,
    output logic [rtcw_pkg::RTCW_DW-1:0] alarm_config_repeat_reg,
    output logic timer_write_enable
);
    import rtcw_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // decode helpers

    // byte slot from pointer and half
    function automatic logic [2:0] slot_of(input logic [1:0] p, input logic hi);
        slot_of = {p, hi};
    endfunction

    // whether a slot holds a real register in the chosen window
    function automatic logic slot_live(input logic win, input logic [1:0] p, input logic hi);
        if (win == RTCW_WIN_VALUE) begin
            slot_live = !(p == RTCW_PTR_YEAR && hi);
        end else begin
            slot_live = (p != RTCW_PTR_YEAR);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pointers

    logic [RTCW_PW-1:0] value_pointer; // value window pointer
    logic [RTCW_PW-1:0] alarm_pointer; // alarm window pointer
    logic val_dec; // value pointer step
    logic alm_dec; // alarm pointer step
    logic [RTCW_PW-1:0] sel_ptr; // pointer of the addressed window

    // reads of either byte and writes of the high byte step the pointer
    always_comb begin
        val_dec = (win_sel == RTCW_WIN_VALUE) && (win_rd || (win_wr && be_hi));
        alm_dec = (win_sel == RTCW_WIN_ALARM) && (win_rd || (win_wr && be_hi));
        sel_ptr = (win_sel == RTCW_WIN_VALUE) ? value_pointer : alarm_pointer;
    end

    // value pointer, loaded from config bits 9:8
    rtcw_ptr u_val_ptr (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .load(cfg_wr),
        .load_val(cfg_wdata[RTCW_PTR_MSB:RTCW_PTR_LSB]),
        .dec(val_dec),
        .ptr(value_pointer)
    );

    // alarm pointer, loaded from alarm config bits 9:8
    rtcw_ptr u_alm_ptr (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .load(alcfg_wr),
        .load_val(alcfg_wdata[RTCW_PTR_MSB:RTCW_PTR_LSB]),
        .dec(alm_dec),
        .ptr(alarm_pointer)
    );

    ////////////////////////////////////////////////////////////////////////
    // write-enable lock

    rtcw_unlock_e ul_state; // unlock window state
    rtcw_unlock_e next_ul_state;
    logic [3:0] ul_cnt; // cycles left in the window
    logic [3:0] next_ul_cnt;
    logic next_timer_write_enable;
    logic set_ok; // a set attempt lands in the window

    // window opens on unlock completion and lasts one instruction cycle
    always_comb begin
        next_ul_state = ul_state;
        next_ul_cnt = ul_cnt;
        set_ok = unlock_done || (ul_state == RTCW_ARMED);
        case (ul_state)
            RTCW_LOCKED: begin
                if (unlock_done) begin
                    next_ul_state = RTCW_ARMED;
                    next_ul_cnt = RTCW_UNLOCK_CYC;
                end
            end
            RTCW_ARMED: begin
                if (unlock_done) begin
                    next_ul_cnt = RTCW_UNLOCK_CYC;
                end else if (ul_cnt <= RTCW_CNT_ONE) begin
                    next_ul_state = RTCW_LOCKED;
                    next_ul_cnt = RTCW_CNT_ZERO;
                end else begin
                    next_ul_cnt = ul_cnt - RTCW_CNT_ONE;
                end
            end
            default: begin
                next_ul_state = RTCW_LOCKED;
                next_ul_cnt = RTCW_CNT_ZERO;
            end
        endcase
        // clearing is always allowed; setting only inside the window
        next_timer_write_enable = timer_write_enable;
        if (cfg_wr) begin
            if (!cfg_wdata[RTCW_WREN_BIT]) begin
                next_timer_write_enable = 1'b0;
            end else if (set_ok) begin
                next_timer_write_enable = 1'b1;
            end
        end
    end

    // register the lock state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ul_state <= RTCW_LOCKED;
            ul_cnt <= RTCW_CNT_ZERO;
            timer_write_enable <= 1'b0;
        end else if (ce) begin
            ul_state <= next_ul_state;
            ul_cnt <= next_ul_cnt;
            timer_write_enable <= next_timer_write_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register bytes and read path

    logic [RTCW_SLOTS-1:0][RTCW_BW-1:0] time_q; // time bytes by slot
    logic [RTCW_SLOTS-1:0][RTCW_BW-1:0] alarm_q; // alarm bytes by slot
    logic [RTCW_SLOTS-1:0][RTCW_BW-1:0] next_time_q;
    logic [RTCW_SLOTS-1:0][RTCW_BW-1:0] next_alarm_q;
    logic [RTCW_DW-1:0] next_rd_data;
    logic next_rd_valid;
    logic [2:0] s_hi; // slot of the high byte
    logic [2:0] s_lo; // slot of the low byte
    logic wr_time_ok; // time write passes the lock

    // byte writes into the addressed pair; read picks the pair before stepping
    always_comb begin
        next_time_q = time_q;
        next_alarm_q = alarm_q;
        s_hi = slot_of(sel_ptr, 1'b1);
        s_lo = slot_of(sel_ptr, 1'b0);
        wr_time_ok = win_wr && timer_write_enable;
        if (win_sel == RTCW_WIN_VALUE) begin
            if (wr_time_ok && be_hi && slot_live(win_sel, sel_ptr, 1'b1)) begin
                next_time_q[s_hi] = win_wdata[RTCW_DW-1:RTCW_BW];
            end
            if (wr_time_ok && be_lo && slot_live(win_sel, sel_ptr, 1'b0)) begin
                next_time_q[s_lo] = win_wdata[RTCW_BW-1:0];
            end
        end else begin
            if (win_wr && be_hi && slot_live(win_sel, sel_ptr, 1'b1)) begin
                next_alarm_q[s_hi] = win_wdata[RTCW_DW-1:RTCW_BW];
            end
            if (win_wr && be_lo && slot_live(win_sel, sel_ptr, 1'b0)) begin
                next_alarm_q[s_lo] = win_wdata[RTCW_BW-1:0];
            end
        end
        next_rd_valid = win_rd;
        next_rd_data = rd_data;
        if (win_rd) begin
            next_rd_data = RTCW_WORD_RST; // unmapped bytes read zero
            if (slot_live(win_sel, sel_ptr, 1'b1)) begin
                next_rd_data[RTCW_DW-1:RTCW_BW] = (win_sel == RTCW_WIN_VALUE) ? time_q[s_hi] : alarm_q[s_hi];
            end
            if (slot_live(win_sel, sel_ptr, 1'b0)) begin
                next_rd_data[RTCW_BW-1:0] = (win_sel == RTCW_WIN_VALUE) ? time_q[s_lo] : alarm_q[s_lo];
            end
        end
    end

    // register bytes and the read answer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            time_q <= '0;
            alarm_q <= '0;
            rd_data <= RTCW_WORD_RST;
            rd_valid <= 1'b0;
        end else if (ce) begin
            time_q <= next_time_q;
            alarm_q <= next_alarm_q;
            rd_data <= next_rd_data;
            rd_valid <= next_rd_valid;
        end
    end

    // configuration views built from live state
    always_comb begin
        rtc_config_calibration_reg = RTCW_WORD_RST;
        rtc_config_calibration_reg[RTCW_PTR_MSB:RTCW_PTR_LSB] = value_pointer;
        rtc_config_calibration_reg[RTCW_WREN_BIT] = timer_write_enable;
        alarm_config_repeat_reg = RTCW_WORD_RST;
        alarm_config_repeat_reg[RTCW_PTR_MSB:RTCW_PTR_LSB] = alarm_pointer;
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions

    sequence unlock_s;
        ce && unlock_done;
    endsequence

    sequence set_try_s;
        ce && cfg_wr && cfg_wdata[RTCW_WREN_BIT];
    endsequence

    val_read_step_a: assert property (@(posedge clk) disable iff (!resetn)
        ce && win_rd && win_sel == RTCW_WIN_VALUE && !cfg_wr && value_pointer != RTCW_PTR_MIN_SEC
        |=> value_pointer == $past(value_pointer) - RTCW_PTR_STEP)
        else $error("value pointer did not step on read");

    val_floor_a: assert property (@(posedge clk) disable iff (!resetn)
        ce && win_wr && be_hi && win_sel == RTCW_WIN_VALUE && !cfg_wr && value_pointer == RTCW_PTR_MIN_SEC
        |=> value_pointer == RTCW_PTR_MIN_SEC)
        else $error("value pointer left zero");

    low_write_hold_a: assert property (@(posedge clk) disable iff (!resetn)
        ce && win_wr && !be_hi && !win_rd && !cfg_wr |=> $stable(value_pointer))
        else $error("low byte write moved pointer");

    alarm_hi_step_a: assert property (@(posedge clk) disable iff (!resetn)
        ce && win_wr && be_hi && win_sel == RTCW_WIN_ALARM && !alcfg_wr && alarm_pointer != RTCW_PTR_MIN_SEC
        |=> alarm_pointer == $past(alarm_pointer) - RTCW_PTR_STEP)
        else $error("alarm pointer did not step on high write");

    wren_in_window_a: assert property (@(posedge clk) disable iff (!resetn)
        unlock_s ##1 set_try_s |=> timer_write_enable)
        else $error("enable set refused inside window");

    wren_no_unlock_a: assert property (@(posedge clk) disable iff (!resetn)
        ce && !unlock_done ##1 (set_try_s and (!unlock_done && !timer_write_enable)) |=> !timer_write_enable)
        else $error("enable set outside window");

    locked_write_a: assert property (@(posedge clk) disable iff (!resetn)
        ce && win_wr && win_sel == RTCW_WIN_VALUE && !timer_write_enable |=> $stable(time_q))
        else $error("locked time write changed a register");

    ptr_load_a: assert property (@(posedge clk) disable iff (!resetn)
        ce && cfg_wr |=> value_pointer == $past(cfg_wdata[RTCW_PTR_MSB:RTCW_PTR_LSB]))
        else $error("value pointer load lost");

    year_high_zero_a: assert property (@(posedge clk) disable iff (!resetn)
        ce && win_rd && win_sel == RTCW_WIN_VALUE && value_pointer == RTCW_PTR_YEAR
        |=> rd_valid && rd_data[RTCW_DW-1:RTCW_BW] == RTCW_BYTE_RST
        && rd_data[RTCW_BW-1:0] == $past(time_q[slot_of(RTCW_PTR_YEAR, 1'b0)]))
        else $error("year pair read wrong");

    alarm_void_a: assert property (@(posedge clk) disable iff (!resetn)
        ce && win_rd && win_sel == RTCW_WIN_ALARM && alarm_pointer == RTCW_PTR_YEAR |=> rd_data == RTCW_WORD_RST)
        else $error("alarm pointer 11 returned data");
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// self-checking bench for the clock/calendar register window access block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import rtcw_pkg::*;
    // stimulus and observed signals
    logic clk, resetn, ce, cfg_wr, alcfg_wr, unlock_done, win_rd, win_wr, win_sel, be_hi, be_lo;
    logic [RTCW_DW-1:0] cfg_wdata, alcfg_wdata, win_wdata, rd_data, cfg_view, al_view;
    logic rd_valid, wren;
    // bookkeeping
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;

    ////////////////////////////////////////////////////////////////////////
    rtcw_access dut (
        .clk(clk), .resetn(resetn), .ce(ce),
        .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .alcfg_wr(alcfg_wr), .alcfg_wdata(alcfg_wdata),
        .unlock_done(unlock_done), .win_rd(win_rd), .win_wr(win_wr), .win_sel(win_sel),
        .be_hi(be_hi), .be_lo(be_lo), .win_wdata(win_wdata), .rd_data(rd_data), .rd_valid(rd_valid),
        .rtc_config_calibration_reg(cfg_view), .alarm_config_repeat_reg(al_view),
        .timer_write_enable(wren)
    );

    // 4 ns clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // hang guard: the whole run needs under a hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // step to just after the next rising edge
    task automatic tick;
        @(posedge clk);
        #1;
    endtask

    // word comparison
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // flag comparison
    task automatic chk1(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask

    // distinct byte per slot, slot = pointer * 2 + high flag
    function automatic logic [7:0] pat(input int s);
        return 8'(s * 33 + 16);
    endfunction

    // word written at a value pointer, and alarm variant
    function automatic logic [15:0] vword(input int p);
        return {pat(2 * p + 1), pat(2 * p)};
    endfunction

    // value window read at pointer: high byte of pointer 3 is unmapped
    function automatic logic [15:0] vexp(input int p);
        return (p == 3) ? {8'h00, pat(6)} : vword(p);
    endfunction

    // alarm window read at pointer: pointer 3 maps nothing
    function automatic logic [15:0] aexp(input int p);
        return (p == 3) ? 16'h0000 : (vword(p) ^ 16'h5a5a);
    endfunction

    // expected register views
    function automatic logic [15:0] cview(input int p, input logic e);
        return {2'b00, e, 3'h0, 2'(p), 8'h00};
    endfunction

    function automatic logic [15:0] aview(input int p);
        return {6'h00, 2'(p), 8'h00};
    endfunction

    // config write; an enable request is preceded by the unlock pulse
    task automatic set_cfg(input int p, input logic e);
        if (e) begin
            unlock_done = 1'b1;
            tick();
            unlock_done = 1'b0;
        end
        cfg_wr = 1'b1;
        cfg_wdata = cview(p, e);
        tick();
        cfg_wr = 1'b0;
        tick();
    endtask

    // alarm config write
    task automatic set_alcfg(input int p);
        alcfg_wr = 1'b1;
        alcfg_wdata = aview(p);
        tick();
        alcfg_wr = 1'b0;
        tick();
    endtask

    // window write
    task automatic wwr(input logic s, input logic h, input logic l, input logic [15:0] d);
        win_wr = 1'b1;
        win_sel = s;
        be_hi = h;
        be_lo = l;
        win_wdata = d;
        tick();
        win_wr = 1'b0;
        tick();
    endtask

    // window read: answer one cycle later, valid lasts one cycle
    task automatic rd_chk(input logic s, input logic h, input logic l, input logic [15:0] exp);
        win_rd = 1'b1;
        win_sel = s;
        be_hi = h;
        be_lo = l;
        tick();
        win_rd = 1'b0;
        chk1("rd_valid", 1'b1, rd_valid);
        chk("rd_data", exp, rd_data);
        tick();
        chk1("rd_valid end", 1'b0, rd_valid);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // state right after reset
    task automatic s_reset;
        chk("rd_data", 16'h0000, rd_data);
        chk("cfg view", 16'h0000, cfg_view);
        chk("alarm view", 16'h0000, al_view);
        chk1("write enable", 1'b0, wren);
    endtask

    // enable refused without a fresh unlock, then granted
    task automatic s_lock;
        set_cfg(3, 1'b0);
        cfg_wr = 1'b1;
        cfg_wdata = cview(3, 1'b1);
        tick();
        cfg_wr = 1'b0;
        chk("cfg view", cview(3, 1'b0), cfg_view);
        unlock_done = 1'b1;
        tick();
        unlock_done = 1'b0;
        tick();
        cfg_wr = 1'b1;
        tick();
        cfg_wr = 1'b0;
        chk1("late enable", 1'b0, wren);
        wwr(1'b0, 1'b1, 1'b1, 16'hffff);
        chk("locked step", cview(2, 1'b0), cfg_view);
        set_cfg(3, 1'b1);
        chk1("write enable", 1'b1, wren);
        chk("cfg view", cview(3, 1'b1), cfg_view);
    endtask

    // fill, step and read back the value window
    task automatic s_value;
        for (int p = 3; p >= 0; p--) begin
            wwr(1'b0, 1'b1, 1'b1, vword(p));
            chk("value ptr", cview((p > 0) ? p - 1 : 0, 1'b1), cfg_view);
        end
        wwr(1'b0, 1'b1, 1'b1, vword(0));
        chk("value ptr hold", cview(0, 1'b1), cfg_view);
        set_cfg(1, 1'b1);
        wwr(1'b0, 1'b0, 1'b1, vword(1));
        chk("low write no step", cview(1, 1'b1), cfg_view);
        set_cfg(3, 1'b0);
        chk1("enable cleared", 1'b0, wren);
        for (int p = 3; p >= 0; p--) begin
            rd_chk(1'b0, 1'(p), 1'b1, vexp(p));
            chk("read step", cview((p > 0) ? p - 1 : 0, 1'b0), cfg_view);
        end
        set_cfg(2, 1'b0);
        wwr(1'b0, 1'b1, 1'b1, 16'hffff);
        chk("locked step", cview(1, 1'b0), cfg_view);
        set_cfg(2, 1'b0);
        rd_chk(1'b0, 1'b1, 1'b1, vexp(2));
    endtask

    // alarm window fill with pointer steps, a frozen cycle, then read back
    task automatic s_alarm;
        set_alcfg(3);
        chk("alarm view", aview(3), al_view);
        for (int p = 3; p >= 0; p--) begin
            wwr(1'b1, 1'b1, 1'b1, vword(p) ^ 16'h5a5a);
            chk("alarm ptr", aview((p > 0) ? p - 1 : 0), al_view);
        end
        set_alcfg(2);
        ce = 1'b0;
        win_rd = 1'b1;
        win_sel = 1'b1;
        tick();
        win_rd = 1'b0;
        ce = 1'b1;
        chk1("frozen read", 1'b0, rd_valid);
        chk("frozen ptr", aview(2), al_view);
        tick();
        set_alcfg(3);
        for (int p = 3; p >= 0; p--) begin
            rd_chk(1'b1, 1'b1, 1'(p), aexp(p));
            chk("alarm read step", aview((p > 0) ? p - 1 : 0), al_view);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic conclude;
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        {resetn, cfg_wr, alcfg_wr, unlock_done, win_rd, win_wr, win_sel, be_hi, be_lo} = '0;
        ce = 1'b1;
        cfg_wdata = '0;
        alcfg_wdata = '0;
        win_wdata = '0;
        repeat (16) @(posedge clk);
        #1;
        resetn = 1'b1;
        s_reset();
        s_lock();
        s_value();
        s_alarm();
        conclude();
    end
endmodule
`default_nettype wire
